//--- design/flash_erase_map.svh
// Purpose: named constants of the serial flash erase engine
// Assumes: included by its bare name wherever a constant is needed
// Notes:   definitions only
`ifndef FLASH_ERASE_MAP_SVH
`define FLASH_ERASE_MAP_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define OPC_BULK_ERASE        8'hC7
`define OPC_SECTOR_ERASE      8'hD8
`define OPC_SUBSECTOR_DEFAULT 8'h20
`define OPC_WREN_DEFAULT      8'h06
`define OPC_WRDI_DEFAULT      8'h04
`define OPC_RDSR_DEFAULT      8'h05

// ----------------------------------------------------------------------
// frame lengths in serial clock edges
// ----------------------------------------------------------------------
`define OPCODE_BITS           7'h08
`define ADDR3_FRAME_BITS      7'h20
`define ADDR4_FRAME_BITS      7'h28
`define FRAME_BITS_MAX        7'h7F
`define FRAME_BITS_FIRST      7'h01
`define PHASE_FIRST           3'h1
`define PHASE_MSB             3'h7
`define ADDR3_WIDTH           24

// ----------------------------------------------------------------------
// status byte layout
// ----------------------------------------------------------------------
`define STATUS_WIP_BIT        0
`define STATUS_WEL_BIT        1
`define STATUS_RESERVED       6'h00

// ----------------------------------------------------------------------
// array geometry and timing
// ----------------------------------------------------------------------
`define ARRAY_ADDR_BITS       24
`define SECTOR_OFFSET_BITS    16
`define SUBSECTOR_OFFSET_BITS 12
`define ERASED_BYTE           8'hFF
`define CLOCK_HZ              10000000
`define MS_PER_S              1000
`define BULK_ERASE_TIME_MS    30000
`define SECTOR_ERASE_TIME_MS  700
`define SUBSECTOR_ERASE_TIME_MS 300
`define TIMER_LAST            32'h0000_0001
`define ADDR_ZERO             32'h0000_0000

`endif

//--- design/flash_erase_pkg.sv
// Purpose: types shared by the serial flash erase engine
// Assumes: nothing
// Notes:   state records of both clock domains
package flash_erase_pkg;

  // ----------------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ENG_IDLE, ENG_ERASING} engine_state_t;
  typedef enum logic [1:0] {ERASE_BULK, ERASE_SECTOR, ERASE_SUBSECTOR} erase_kind_t;

  // ----------------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------------
  typedef struct packed {
    engine_state_t state;
    logic [31:0]   timer;
    logic          wip;
    logic          wel;
    erase_kind_t   kind;
    logic [31:0]   first_addr;
    logic [31:0]   last_addr;
    logic          start;
    logic          power_active;
    logic          cs_high_d;
    logic          frame_seen;
  } core_state_t;

  typedef struct packed {
    logic [6:0]  bits;
    logic [2:0]  phase;
    logic [7:0]  opcode;
    logic [31:0] addr;
    logic        frame_tog;
  } link_rx_t;

  typedef struct packed {
    logic data;
    logic en;
  } link_tx_t;

endpackage

//--- design/serial_flash_erase_engine.sv
// Purpose: erase command handling and power mode of a serial flash
// Assumes: host drives chip select, serial clock and serial data in
// Notes:   array itself sits outside; this block issues erase ranges
//
// Summary of operation
// RL1 - bulk erase opcode sets whole array to ones.
// RL2 - host sends write enable before bulk erase.
// RL3 - host shifts eight opcode bits, then raises chip select.
// RL4 - bulk erase cycle starts when chip select rises after valid command.
// RL5 - busy bit reads one during erase, zero after; readable by status read.
// RL6 - write enable latch clears before any erase cycle completes.
// RL7 - host waits or polls busy before touching memory after bulk erase.
// RL8 - sector erase sets addressed sector to ones, others untouched.
// RL9 - host sends write enable before sector erase.
// RL10 - sector erase carries three or four address bytes per mode.
// RL11 - any address inside a sector selects whole sector.
// RL12 - sector erase cycle starts when chip select rises.
// RL13 - host waits or polls busy before next page program.
// RL14 - subsector erase sets addressed subsector to ones.
// RL15 - subsector erase carries address; any inside address selects it.
// RL16 - subsector erase cycle starts when chip select rises.
// RL17 - four byte mode gives 32 bit address fields.
// RL18 - chip select low means active power mode.
// RL19 - after deselect stay active until internal cycles finish.
// RL20 - every host bit is sampled on serial clock rising edge.
// RL21 - read commands during a cycle are ignored.
// RL22 - erase with write enable latch clear is ignored.
// RL23 - erase during a running cycle is ignored.
`timescale 1ns/10ps
`include "flash_erase_map.svh"
module serial_flash_erase_engine #(
  parameter int unsigned CYCLES_PER_MS     = `CLOCK_HZ / `MS_PER_S,
  parameter int unsigned BULK_CYCLES       = `BULK_ERASE_TIME_MS * CYCLES_PER_MS,
  parameter int unsigned SECTOR_CYCLES     = `SECTOR_ERASE_TIME_MS * CYCLES_PER_MS,
  parameter int unsigned SUBSECTOR_CYCLES  = `SUBSECTOR_ERASE_TIME_MS * CYCLES_PER_MS,
  parameter int          ARRAY_ADDR_BITS   = `ARRAY_ADDR_BITS,
  parameter int          SECTOR_BITS       = `SECTOR_OFFSET_BITS,
  parameter int          SUBSECTOR_BITS    = `SUBSECTOR_OFFSET_BITS,
  parameter logic [7:0]  OPC_SUBSECTOR     = `OPC_SUBSECTOR_DEFAULT,
  parameter logic [7:0]  OPC_WRITE_ENABLE  = `OPC_WREN_DEFAULT,
  parameter logic [7:0]  OPC_WRITE_DISABLE = `OPC_WRDI_DEFAULT,
  parameter logic [7:0]  OPC_READ_STATUS   = `OPC_RDSR_DEFAULT
) (
  // core clock and reset
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  // serial link from the host
  input  wire logic                         serial_clock_pin,
  input  wire logic                         chip_select_n,
  input  wire logic                         serial_data_in_line,
  output logic                              serial_data_out_line,
  output logic                              serial_data_out_oe,
  // configuration
  input  wire logic                         four_byte_mode,
  // erase request to the array
  output logic                              erase_start,
  output flash_erase_pkg::erase_kind_t      erase_kind,
  output logic [31:0]                       erase_first_addr,
  output logic [31:0]                       erase_last_addr,
  output logic [7:0]                        erase_fill_byte,
  // status and power
  output logic                              write_in_progress,
  output logic                              write_enable_latch,
  output logic                              active_power_mode
);
  import flash_erase_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // offset mask of the region an erase covers
  function automatic logic [31:0] region_mask(input erase_kind_t kind);
    logic [31:0] m;
    m = `ADDR_ZERO;
    unique case (kind)
      ERASE_BULK:      m = (32'h0000_0001 << ARRAY_ADDR_BITS) - 32'h0000_0001;
      ERASE_SECTOR:    m = (32'h0000_0001 << SECTOR_BITS) - 32'h0000_0001;
      ERASE_SUBSECTOR: m = (32'h0000_0001 << SUBSECTOR_BITS) - 32'h0000_0001;
      default:         m = `ADDR_ZERO;
    endcase
    return m;
  endfunction

  // edges a frame with an address field must hold
  function automatic logic [6:0] addr_frame_bits(input logic four_byte);
    return four_byte ? `ADDR4_FRAME_BITS : `ADDR3_FRAME_BITS;
  endfunction

  // opcode-only command: any trailing bit makes it a different frame
  function automatic logic bare_cmd(input link_rx_t r, input logic [7:0] c);
    return (r.bits == `OPCODE_BITS) && (r.opcode == c);
  endfunction

  // ----------------------------------------------------------------------
  // link domain: receive shifter
  // ----------------------------------------------------------------------
  link_rx_t    rx_r;
  link_rx_t    rx_nxt;
  link_tx_t    tx_r;
  link_tx_t    tx_nxt;
  logic        frame_active_r;
  logic        link_clear_n;
  logic [1:0]  status_link;
  logic [7:0]  status_byte_link;

  // frame flag clears as chip select rises; captured fields survive it
  assign link_clear_n = reset_n & ~chip_select_n;

  // marks the first serial clock edge of each frame
  always_ff @(posedge serial_clock_pin or negedge link_clear_n) begin
    if (!link_clear_n) begin
      frame_active_r <= 1'b0;
    end else begin
      frame_active_r <= 1'b1;
    end
  end

  // opcode then address, msb first, one bit per rising edge
  always_comb begin
    rx_nxt = rx_r;
    if (!frame_active_r) begin
      rx_nxt.bits      = `FRAME_BITS_FIRST;
      rx_nxt.phase     = `PHASE_FIRST;
      rx_nxt.opcode    = {7'h00, serial_data_in_line};                 // [RL20]
      rx_nxt.addr      = `ADDR_ZERO;
      rx_nxt.frame_tog = ~rx_r.frame_tog;
    end else begin
      rx_nxt.phase = rx_r.phase + 3'h1;
      if (rx_r.bits != `FRAME_BITS_MAX) begin
        rx_nxt.bits = rx_r.bits + 7'h01;
      end
      if (rx_r.bits < `OPCODE_BITS) begin
        rx_nxt.opcode = {rx_r.opcode[6:0], serial_data_in_line};       // [RL20] [RL3]
      end else begin
        rx_nxt.addr = {rx_r.addr[30:0], serial_data_in_line};          // [RL20] [RL10] [RL15]
      end
    end
  end

  // receive record
  always_ff @(posedge serial_clock_pin or negedge reset_n) begin
    if (!reset_n) begin
      rx_r <= '0;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // link domain: status read-out
  // ----------------------------------------------------------------------

  // serial clock only runs inside frames; opcode edges let this settle
  sync_2ff #(
    .WIDTH       (2),
    .RESET_VALUE (32'h0000_0000)
  ) u_status_sync (
    .clock   (serial_clock_pin),
    .reset_n (reset_n),
    .d       ({write_enable_latch, write_in_progress}),
    .q       (status_link)
  );

  // status byte, reserved bits zero
  always_comb begin
    status_byte_link                  = {`STATUS_RESERVED, 2'b00};
    status_byte_link[`STATUS_WIP_BIT] = status_link[0];
    status_byte_link[`STATUS_WEL_BIT] = status_link[1];
  end

  // only the status read drives out; other reads stay silent while busy
  always_comb begin
    tx_nxt = tx_r;
    if (frame_active_r && (rx_r.bits >= `OPCODE_BITS)
        && (rx_r.opcode == OPC_READ_STATUS)) begin
      tx_nxt.en   = 1'b1;                                              // [RL5] [RL21]
      tx_nxt.data = status_byte_link[`PHASE_MSB - rx_r.phase];         // [RL5]
    end else begin
      tx_nxt.en   = 1'b0;                                              // [RL21]
      tx_nxt.data = 1'b0;
    end
  end

  // falling edge launch, released at once when chip select rises
  always_ff @(negedge serial_clock_pin or negedge link_clear_n) begin
    if (!link_clear_n) begin
      tx_r <= '0;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  assign serial_data_out_line = tx_r.data;
  assign serial_data_out_oe   = tx_r.en;

  // ----------------------------------------------------------------------
  // core domain: synchronisers
  // ----------------------------------------------------------------------
  logic cs_high_sync;
  logic four_byte_sync;

  // chip select idles high
  sync_2ff #(
    .WIDTH       (1),
    .RESET_VALUE (32'h0000_0001)
  ) u_cs_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .d       (chip_select_n),
    .q       (cs_high_sync)
  );

  // address mode strap or configuration level
  sync_2ff #(
    .WIDTH       (1),
    .RESET_VALUE (32'h0000_0000)
  ) u_mode_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .d       (four_byte_mode),
    .q       (four_byte_sync)
  );

  // ----------------------------------------------------------------------
  // core domain: command decode and erase timer
  // ----------------------------------------------------------------------
  core_state_t st_r;
  core_state_t st_nxt;
  logic        frame_end;
  logic        new_frame;
  logic [31:0] cmd_addr;
  logic        is_erase;
  logic        len_ok;
  erase_kind_t cmd_kind;
  logic [31:0] cmd_cycles;

  // link fields are frozen while chip select is high, so they are read
  // here without their own crossing; a new frame within three core clocks
  // of the last one could race this sampling
  assign frame_end = cs_high_sync & ~st_r.cs_high_d;
  assign new_frame = rx_r.frame_tog != st_r.frame_seen;

  // address width follows the active mode
  assign cmd_addr = four_byte_sync ? rx_r.addr                         // [RL17]
                                   : {8'h00, rx_r.addr[`ADDR3_WIDTH-1:0]};

  // classify the received opcode and its length
  always_comb begin
    is_erase   = 1'b0;
    len_ok     = 1'b0;
    cmd_kind   = ERASE_BULK;
    cmd_cycles = BULK_CYCLES;
    if (rx_r.opcode == `OPC_BULK_ERASE) begin
      is_erase = 1'b1;
      len_ok   = rx_r.bits == `OPCODE_BITS;                            // [RL3]
    end else if (rx_r.opcode == `OPC_SECTOR_ERASE) begin
      is_erase   = 1'b1;
      cmd_kind   = ERASE_SECTOR;
      cmd_cycles = SECTOR_CYCLES;
      len_ok     = rx_r.bits == addr_frame_bits(four_byte_sync);       // [RL10]
    end else if (rx_r.opcode == OPC_SUBSECTOR) begin
      is_erase   = 1'b1;
      cmd_kind   = ERASE_SUBSECTOR;
      cmd_cycles = SUBSECTOR_CYCLES;
      len_ok     = rx_r.bits == addr_frame_bits(four_byte_sync);       // [RL15]
    end
  end

  // engine next state
  always_comb begin
    st_nxt              = st_r;
    st_nxt.start        = 1'b0;
    st_nxt.cs_high_d    = cs_high_sync;
    if (frame_end) begin
      st_nxt.frame_seen = rx_r.frame_tog;
    end
    unique case (st_r.state)
      ENG_IDLE: begin
        if (frame_end && new_frame) begin
          if (bare_cmd(rx_r, OPC_WRITE_ENABLE)) begin
            st_nxt.wel = 1'b1;
          end else if (bare_cmd(rx_r, OPC_WRITE_DISABLE)) begin
            st_nxt.wel = 1'b0;
          end else if (is_erase && len_ok && st_r.wel) begin           // [RL22]
            st_nxt.state      = ENG_ERASING;                           // [RL4] [RL12] [RL16]
            st_nxt.start      = 1'b1;
            st_nxt.wip        = 1'b1;                                  // [RL5]
            st_nxt.wel        = 1'b0;                                  // [RL6]
            st_nxt.timer      = cmd_cycles;
            st_nxt.kind       = cmd_kind;
            if (cmd_kind == ERASE_BULK) begin
              st_nxt.first_addr = `ADDR_ZERO;                          // [RL1]
              st_nxt.last_addr  = region_mask(cmd_kind);               // [RL1]
            end else begin
              st_nxt.first_addr = cmd_addr & ~region_mask(cmd_kind);   // [RL11] [RL8] [RL14]
              st_nxt.last_addr  = cmd_addr | region_mask(cmd_kind);    // [RL11] [RL8] [RL14]
            end
          end
        end
      end
      ENG_ERASING: begin
        // every command, erase or not, is dropped until the cycle ends
        if (st_r.timer <= `TIMER_LAST) begin                           // [RL23]
          st_nxt.state = ENG_IDLE;
          st_nxt.wip   = 1'b0;                                         // [RL5]
          st_nxt.timer = 32'h0000_0000;
        end else begin
          st_nxt.timer = st_r.timer - 32'h0000_0001;
        end
      end
    endcase
    // selected, or still running an internal cycle
    st_nxt.power_active = ~cs_high_sync                                // [RL18]
                        | (st_nxt.state == ENG_ERASING);               // [RL19]
  end

  // engine record
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r           <= '0;
      st_r.cs_high_d <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign erase_start        = st_r.start;
  assign erase_kind         = st_r.kind;
  assign erase_first_addr   = st_r.first_addr;
  assign erase_last_addr    = st_r.last_addr;
  assign erase_fill_byte    = `ERASED_BYTE;                            // [RL1] [RL8] [RL14]
  assign write_in_progress  = st_r.wip;
  assign write_enable_latch = st_r.wel;
  assign active_power_mode  = st_r.power_active;

endmodule

//--- design/sync_2ff.sv
// Purpose: two-stage level synchroniser
// Assumes: input is a level that is stable for several destination clocks
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module sync_2ff #(
  parameter int          WIDTH       = 1,
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  // destination clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // metastability guard: meta_r is read by q only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= RESET_VALUE[WIDTH-1:0];
      q      <= RESET_VALUE[WIDTH-1:0];
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

//--- tb/flash_erase_checker_sva.sv
// Purpose: port-level checks of the serial flash erase engine
// Assumes: core clock domain only; link pins seen as levels
// Notes:   bound to every instance of the engine
`timescale 1ns/10ps
module flash_erase_checker
  import flash_erase_pkg::*;
(
  // core clock and reset
  input wire logic         clock,
  input wire logic         reset_n,
  // link select level
  input wire logic         chip_select_n,
  // erase request and status
  input wire logic         erase_start,
  input wire erase_kind_t  erase_kind,
  input wire logic [31:0]  erase_first_addr,
  input wire logic [31:0]  erase_last_addr,
  input wire logic         write_in_progress,
  input wire logic         write_enable_latch,
  input wire logic         active_power_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------------
  // erase start
  // ----------------------------------------------------------------------
  start_pulse_a: assert property (erase_start |=> !erase_start)
    else $error("erase start longer than one cycle");
  start_status_a: assert property (erase_start |-> write_in_progress && !write_enable_latch)
    else $error("status bits wrong at erase start");
  start_after_cs_a: assert property (erase_start |-> $past(chip_select_n, 2))
    else $error("erase started without deselect");
  start_needs_wel_a: assert property (erase_start |-> $past(write_enable_latch))
    else $error("erase started with latch clear");
  busy_no_start_a: assert property ($past(write_in_progress) |-> !erase_start)
    else $error("erase started while busy");
  wip_cause_a: assert property ($rose(write_in_progress) |-> erase_start)
    else $error("busy rose without erase start");
  // range checks; low offset bits must be ignored
  bulk_range_a: assert property (erase_start && erase_kind == ERASE_BULK |->
    erase_first_addr == 32'h0000_0000 && erase_last_addr == 32'h00FF_FFFF)
    else $error("bulk range wrong");
  sector_range_a: assert property (erase_start && erase_kind == ERASE_SECTOR |->
    erase_first_addr[15:0] == 16'h0000 &&
    erase_last_addr == {erase_first_addr[31:16], 16'hFFFF})
    else $error("sector range wrong");

  // ----------------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------------
  cs_active_a: assert property (!chip_select_n [*4] |-> active_power_mode)
    else $error("standby while selected");
  busy_active_a: assert property (write_in_progress && $past(write_in_progress)
    |-> active_power_mode)
    else $error("standby while busy");
  standby_a: assert property ((chip_select_n && !write_in_progress) [*6]
    |-> !active_power_mode)
    else $error("active while idle and deselected");

  cover property (erase_start && erase_kind == ERASE_BULK);
  cover property (erase_start && erase_kind == ERASE_SECTOR);
  cover property (erase_start && erase_kind == ERASE_SUBSECTOR);
endmodule

bind serial_flash_erase_engine flash_erase_checker u_flash_erase_checker (
  .clock(clock), .reset_n(reset_n), .chip_select_n(chip_select_n),
  .erase_start(erase_start), .erase_kind(erase_kind),
  .erase_first_addr(erase_first_addr), .erase_last_addr(erase_last_addr),
  .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
  .active_power_mode(active_power_mode));

//--- tb/flash_host_model.sv
// Purpose: behavioural host that frames serial commands
// Assumes: serial clock idles low and only runs inside frames
// Notes:   last eight bits seen on the out line kept in rx_r
`timescale 1ns/10ps
module flash_host_model (
  // serial link to the device
  output logic      serial_clock_pin,
  output logic      chip_select_n,
  output logic      serial_data_in_line,
  input  wire logic serial_data_out_line,
  input  wire logic serial_data_out_oe
);
  localparam time HALF = 24;
  logic [7:0] rx_r;

  initial begin
    serial_clock_pin    = 1'b0;
    chip_select_n       = 1'b1;
    serial_data_in_line = 1'b1;
    rx_r                = 8'h00;
  end

  // one frame: opcode, nab address bytes, nrd bytes clocked back
  task automatic frame(input logic [7:0] opc, input logic [31:0] addr,
                       input int nab, input int nrd);
    logic [71:0] sh;
    int          n;
    sh = {opc, addr << (8 * (4 - nab)), 32'h0000_0000};
    n  = 8 + 8 * nab + 8 * nrd;
    #7 chip_select_n = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      serial_data_in_line = sh[71 - i]; // msb first, set while clock low
      #HALF serial_clock_pin = 1'b1;
      // undriven line reads as the inverse, never as stale data
      rx_r = {rx_r[6:0], serial_data_out_oe ? serial_data_out_line : ~serial_data_out_line};
      #HALF serial_clock_pin = 1'b0;
    end
    serial_data_in_line = ~serial_data_in_line; // no stale level once released
    #HALF chip_select_n = 1'b1; // only after the last bit was latched
  endtask
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench of the serial flash erase engine
// Assumes: erase times shortened by parameter
// Notes:   frames come from the host model, checks run in core domain
`timescale 1ns/10ps
`include "flash_erase_map.svh"
module tb_top;
  import flash_erase_pkg::*;
  localparam int BULK_N = 150;
  localparam int SECT_N = 10;
  localparam int SUB_N  = 5;
  localparam int LIMIT  = 6000;

  logic        clock, reset_n, four_byte_mode;
  logic        serial_clock_pin, chip_select_n, serial_data_in_line;
  logic        serial_data_out_line, serial_data_out_oe, erase_start;
  erase_kind_t erase_kind;
  logic [31:0] erase_first_addr, erase_last_addr;
  logic [7:0]  erase_fill_byte;
  logic        write_in_progress, write_enable_latch, active_power_mode;
  int          fails, n_tests, cycles, t0;

  serial_flash_erase_engine #(.BULK_CYCLES(BULK_N), .SECTOR_CYCLES(SECT_N),
    .SUBSECTOR_CYCLES(SUB_N)) u_serial_flash_erase_engine (
    .clock(clock), .reset_n(reset_n), .serial_clock_pin(serial_clock_pin),
    .chip_select_n(chip_select_n), .serial_data_in_line(serial_data_in_line),
    .serial_data_out_line(serial_data_out_line), .serial_data_out_oe(serial_data_out_oe),
    .four_byte_mode(four_byte_mode), .erase_start(erase_start), .erase_kind(erase_kind),
    .erase_first_addr(erase_first_addr), .erase_last_addr(erase_last_addr),
    .erase_fill_byte(erase_fill_byte), .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch), .active_power_mode(active_power_mode));

  flash_host_model u_flash_host_model (
    .serial_clock_pin(serial_clock_pin), .chip_select_n(chip_select_n),
    .serial_data_in_line(serial_data_in_line), .serial_data_out_line(serial_data_out_line),
    .serial_data_out_oe(serial_data_out_oe));

  // ----------------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  // gap keeps deselect above the 300 ns the capture needs
  task automatic gap(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic status(input logic [7:0] exp);
    u_flash_host_model.frame(`OPC_RDSR_DEFAULT, 32'h0000_0000, 0, 1);
    chk({24'h0, u_flash_host_model.rx_r}, {24'h0, exp});
    gap(4);
  endtask

  task automatic wren();
    u_flash_host_model.frame(`OPC_WREN_DEFAULT, 32'h0000_0000, 0, 0);
    gap(5);
  endtask

  task automatic erase(input logic [7:0] opc, input logic [31:0] addr, input int nab,
                       input logic want, input erase_kind_t kind,
                       input logic [31:0] first, input logic [31:0] last);
    logic seen;
    seen = 1'b0;
    u_flash_host_model.frame(opc, addr, nab, 0);
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge clock);
      #2;
      seen = (erase_start === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, want});
    if (want) begin
      t0 = cycles;
      chk({30'h0, erase_kind}, {30'h0, kind});
      chk(erase_first_addr, first);
      chk(erase_last_addr, last);
      chk({30'h0, write_in_progress, write_enable_latch}, 32'h0000_0002);
      chk({24'h0, erase_fill_byte}, {24'h0, `ERASED_BYTE});
      gap(1);
    end
  endtask

  // waits until busy drops, then checks the span from erase start
  task automatic wait_idle(input int span);
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < 400) begin
      @(posedge clock);
      #2;
      n++;
    end
    chk({31'h0, cycles - t0 >= span - 1 && cycles - t0 <= span + 1}, 32'h1);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_no_latch();
    erase(`OPC_BULK_ERASE, 32'h0, 0, 1'b0, ERASE_BULK, 32'h0, 32'h0);
    status(8'h00);
    wren();
    u_flash_host_model.frame(`OPC_WRDI_DEFAULT, 32'h0, 0, 0);
    gap(5);
    status(8'h00);
  endtask

  task automatic t_bulk();
    wren();
    status(8'h02);
    erase(`OPC_BULK_ERASE, 32'h0, 0, 1'b1, ERASE_BULK, 32'h0, 32'h00FF_FFFF);
    chk({31'h0, active_power_mode}, 32'h1);
    status(8'h01);
    u_flash_host_model.frame(8'h03, 32'h0000_1000, 3, 1);
    chk({24'h0, u_flash_host_model.rx_r}, {24'h0, 8'hFF});
    gap(4);
    wren();
    erase(`OPC_SECTOR_ERASE, 32'h0, 3, 1'b0, ERASE_SECTOR, 32'h0, 32'h0);
    chk({31'h0, write_in_progress}, 32'h1);
    wait_idle(BULK_N);
    gap(8);
    chk({31'h0, active_power_mode}, 32'h0);
    status(8'h00);
  endtask

  task automatic t_sector();
    four_byte_mode = 1'b0;
    wren();
    erase(`OPC_SECTOR_ERASE, 32'h0012_3456, 3, 1'b1, ERASE_SECTOR,
          32'h0012_0000, 32'h0012_FFFF);
    wait_idle(SECT_N);
    gap(4);
  endtask

  task automatic t_subsector();
    four_byte_mode = 1'b1;
    gap(4);
    wren();
    erase(`OPC_SUBSECTOR_DEFAULT, 32'h00AB_CDEF, 4, 1'b1, ERASE_SUBSECTOR,
          32'h00AB_C000, 32'h00AB_CFFF);
    wait_idle(SUB_N);
    gap(4);
    erase(`OPC_SUBSECTOR_DEFAULT, 32'h00AB_CDEF, 4, 1'b0, ERASE_SUBSECTOR,
          32'h0, 32'h0);
  endtask

  initial begin
    reset_n        = 1'b0;
    four_byte_mode = 1'b0;
    fails          = 0;
    n_tests        = 0;
    cycles         = 0;
    gap(5);
    reset_n = 1'b1;
    gap(4);
    t_no_latch();
    t_bulk();
    t_sector();
    t_subsector();
    wrap_up();
  end
endmodule
